// ---- hdl/line_driver_enables.sv ----
`default_nettype none

// Functional notes
// - Six transmit enables, channels 0-5, bits 7:6 reserved
// - Enable bit one drives channel line outputs
// - Enable bit zero tri-states both line outputs
// - Master transmit pin gates every transmit driver
// - Second transmit register covers channels 6-11
// - Six independent receive enables, channels 0-5
// - Receive bit one accepts line input pulses
// - Receive bit zero leaves inputs high impedance
// - Channels 6-11 transmit register at 0x80
module line_driver_enables
    import line_enable_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    // Parallel host port
    input  wire logic                     host_cs,
    input  wire logic                     host_wr,
    input  wire logic                     host_rd,
    input  wire logic [7:0]               host_addr,
    input  wire logic [REG_WIDTH-1:0]     host_wdata,
    output var  logic [REG_WIDTH-1:0]     host_rdata,
    // Master transmit enable pin (asynchronous)
    input  wire logic                     transmit_driver_on,
    // Transmit line data from the channel datapaths
    input  wire logic [CHANNEL_COUNT-1:0] tx_pos_data,
    input  wire logic [CHANNEL_COUNT-1:0] tx_neg_data,
    output var  logic [CHANNEL_COUNT-1:0] line_out_positive,
    output var  logic [CHANNEL_COUNT-1:0] line_out_positive_oe,
    output var  logic [CHANNEL_COUNT-1:0] line_out_negative,
    output var  logic [CHANNEL_COUNT-1:0] line_out_negative_oe,
    // Receive line pins, channels 0-5 (asynchronous)
    input  wire logic [RX_CHANNELS-1:0]   line_in_positive,
    input  wire logic [RX_CHANNELS-1:0]   line_in_negative,
    output var  logic [RX_CHANNELS-1:0]   receive_input_on,
    output var  logic [RX_CHANNELS-1:0]   rx_pos_data,
    output var  logic [RX_CHANNELS-1:0]   rx_neg_data
);

    logic [CHANNEL_FIELD_W-1:0]  tx_enable_reg_low_ff;   // Channels 0-5 transmit enables
    logic [CHANNEL_FIELD_W-1:0]  tx_enable_reg_high_ff;  // Channels 6-11 transmit enables
    logic [CHANNEL_FIELD_W-1:0]  rx_enable_reg_low_ff;   // Channels 0-5 receive enables
    logic [CHANNEL_COUNT-1:0]    tx_enable_all;          // Both transmit registers joined
    logic                        master_on_sync;         // Master pin after two stages
    logic [2*RX_CHANNELS-1:0]    line_in_sync;           // Receive pins after two stages
    logic                        wr_hit;                 // Qualified write strobe
    logic                        rd_hit;                 // Qualified read strobe
    logic [REG_WIDTH-1:0]        nxt_rdata;              // Decoded read value

    // Pad a channel field to a full register; reserved bits forced low
    function automatic logic [REG_WIDTH-1:0] pad_field(input logic [CHANNEL_FIELD_W-1:0] field);
        pad_field = {{(REG_WIDTH-CHANNEL_FIELD_W){1'b0}}, field} & ~RESERVED_MASK;
    endfunction : pad_field

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for the pins that arrive from outside this clock
    level_synchronizer #(.WIDTH(1)) u_master_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in (transmit_driver_on),
        .sync_out (master_on_sync)
    );

    level_synchronizer #(.WIDTH(2*RX_CHANNELS)) u_line_in_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in ({line_in_negative, line_in_positive}),
        .sync_out (line_in_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Host strobes; a chip select gates both directions
    assign wr_hit        = host_cs && host_wr;
    assign rd_hit        = host_cs && host_rd;
    assign tx_enable_all = {tx_enable_reg_high_ff, tx_enable_reg_low_ff};

    // Channels 0-5 transmit register; bits 7:6 dropped on write
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tx_enable_reg_low_ff <= TX_ENABLE_LOW_RESET;
        end else if (wr_hit && host_addr == TX_ENABLE_LOW_OFFSET) begin
            tx_enable_reg_low_ff <= host_wdata[CHANNEL_FIELD_W-1:0];
        end
    end

    // Channels 6-11 transmit register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tx_enable_reg_high_ff <= TX_ENABLE_HIGH_RESET;
        end else if (wr_hit && host_addr == TX_ENABLE_HIGH_OFFSET) begin
            tx_enable_reg_high_ff <= host_wdata[CHANNEL_FIELD_W-1:0];
        end
    end

    // Channels 0-5 receive register, one independent bit per channel
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rx_enable_reg_low_ff <= RX_ENABLE_LOW_RESET;
        end else if (wr_hit && host_addr == RX_ENABLE_LOW_OFFSET) begin
            rx_enable_reg_low_ff <= host_wdata[CHANNEL_FIELD_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped addresses answer zero rather than bus garbage
    always_comb begin
        case (host_addr)
            TX_ENABLE_LOW_OFFSET:  nxt_rdata = pad_field(tx_enable_reg_low_ff);
            RX_ENABLE_LOW_OFFSET:  nxt_rdata = pad_field(rx_enable_reg_low_ff);
            TX_ENABLE_HIGH_OFFSET: nxt_rdata = pad_field(tx_enable_reg_high_ff);
            default:               nxt_rdata = UNMAPPED_READ_VALUE;
        endcase
    end

    // Read data held until the next read strobe
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            host_rdata <= READ_DATA_RESET;
        end else if (rd_hit) begin
            host_rdata <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit drivers; master pin ANDed in so one pin can silence a whole card
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            line_out_positive_oe <= '0;
            line_out_negative_oe <= '0;
        end else begin
            line_out_positive_oe <= tx_enable_all & {CHANNEL_COUNT{master_on_sync}};
            line_out_negative_oe <= tx_enable_all & {CHANNEL_COUNT{master_on_sync}};
        end
    end

    // Line data registered alongside its enable so both change on one edge
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            line_out_positive <= '0;
            line_out_negative <= '0;
        end else begin
            line_out_positive <= tx_pos_data;
            line_out_negative <= tx_neg_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receivers; a disabled input presents high impedance and yields no pulses
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            receive_input_on <= '0;
            rx_pos_data      <= '0;
            rx_neg_data      <= '0;
        end else begin
            receive_input_on <= rx_enable_reg_low_ff;
            rx_pos_data      <= line_in_sync[RX_CHANNELS-1:0] & rx_enable_reg_low_ff;
            rx_neg_data      <= line_in_sync[2*RX_CHANNELS-1:RX_CHANNELS] & rx_enable_reg_low_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_write_tx_low;
        wr_hit && host_addr == TX_ENABLE_LOW_OFFSET;
    endsequence

    sequence s_write_tx_high;
        wr_hit && host_addr == TX_ENABLE_HIGH_OFFSET;
    endsequence

    sequence s_read_tx_high;
        rd_hit && !wr_hit && host_addr == TX_ENABLE_HIGH_OFFSET;
    endsequence

    // Written field must land in the register at the taking edge
    property p_tx_low_write;
        s_write_tx_low |=> tx_enable_reg_low_ff == $past(host_wdata[5:0]);
    endproperty
    a_tx_low_write: assert property (p_tx_low_write) else $error("tx low write lost");

    property p_driver_on;
        (master_on_sync && tx_enable_all[0]) |=> line_out_positive_oe[0] && line_out_negative_oe[0];
    endproperty
    a_driver_on: assert property (p_driver_on) else $error("enabled driver not on");

    property p_driver_off;
        1'b1 |=> (line_out_positive_oe & ~$past(tx_enable_all)) == '0;
    endproperty
    a_driver_off: assert property (p_driver_off) else $error("disabled driver still drives");

    property p_master_gate;
        !master_on_sync |=> line_out_positive_oe == '0 && line_out_negative_oe == '0;
    endproperty
    a_master_gate: assert property (p_master_gate) else $error("driver on without master pin");

    // Register edge, then the enable flop edge; master must be up in between
    property p_tx_high_write;
        (s_write_tx_high ##1 master_on_sync) |=> line_out_positive_oe[11:6] == $past(host_wdata[5:0], 2);
    endproperty
    a_tx_high_write: assert property (p_tx_high_write) else $error("channel 6-11 enable wrong");

    property p_rx_write;
        (wr_hit && host_addr == RX_ENABLE_LOW_OFFSET) |=> ##1 receive_input_on == $past(host_wdata[5:0], 2);
    endproperty
    a_rx_write: assert property (p_rx_write) else $error("receive enable not applied");

    property p_rx_pass;
        rx_enable_reg_low_ff[0] |=> rx_pos_data[0] == $past(line_in_sync[0]);
    endproperty
    a_rx_pass: assert property (p_rx_pass) else $error("enabled receiver drops pulses");

    property p_rx_block;
        1'b1 |=> ((rx_pos_data | rx_neg_data) & ~receive_input_on) == '0;
    endproperty
    a_rx_block: assert property (p_rx_block) else $error("disabled receiver passes pulses");

    property p_read_high;
        s_read_tx_high |=> host_rdata[5:0] == $past(tx_enable_reg_high_ff);
    endproperty
    a_read_high: assert property (p_read_high) else $error("read at 0x80 wrong");

    property p_reserved_zero;
        rd_hit |=> host_rdata[7:6] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

endmodule : line_driver_enables

`default_nettype wire

// ---- include/line_enable_pkg.sv ----
`default_nettype none

package line_enable_pkg;

    // Register offsets on the parallel host port
    localparam logic [7:0] TX_ENABLE_LOW_OFFSET  = 8'h00;  // Transmit enables, channels 0-5
    localparam logic [7:0] RX_ENABLE_LOW_OFFSET  = 8'h08;  // Receive enables, channels 0-5
    localparam logic [7:0] TX_ENABLE_HIGH_OFFSET = 8'h80;  // Transmit enables, channels 6-11

    // Field layout of all three registers
    localparam int         REG_WIDTH       = 8;      // Host data width
    localparam int         CHANNEL_FIELD_W = 6;      // Bits 5..0 hold one channel each
    localparam int         CHANNEL_COUNT   = 12;     // Line channels in the device
    localparam int         RX_CHANNELS     = 6;      // Receive channels controlled here
    localparam logic [7:0] RESERVED_MASK   = 8'hC0;  // Bits 7 and 6 read zero

    // Reset values; drivers and receivers start off, which is the safe redundancy state
    localparam logic [5:0] TX_ENABLE_LOW_RESET  = 6'h00;
    localparam logic [5:0] TX_ENABLE_HIGH_RESET = 6'h00;
    localparam logic [5:0] RX_ENABLE_LOW_RESET  = 6'h00;
    localparam logic [7:0] READ_DATA_RESET      = 8'h00;

    // Answer to an unmapped read
    localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

endpackage : line_enable_pkg

`default_nettype wire

// ---- hdl/level_synchronizer.sv ----
`default_nettype none

module level_synchronizer #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one_ff;  // Only read by the second stage

    ////////////////////////////////////////////////////////////////////////////////
    // Two-stage capture; settles metastability before any logic looks at it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stage_one_ff <= '0;
            sync_out     <= '0;
        end else begin
            stage_one_ff <= async_in;
            sync_out     <= stage_one_ff;
        end
    end

endmodule : level_synchronizer

`default_nettype wire

// ---- verification/line_driver_redundancy_enables_tb.sv ----
`default_nettype none

module line_driver_redundancy_enables_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import line_enable_pkg::*;

    logic                     clk_sys;               // 100 MHz system clock
    logic                     reset;                 // Asynchronous, active high
    logic                     host_cs;               // Host chip select
    logic                     host_wr;               // Host write strobe
    logic                     host_rd;               // Host read strobe
    logic [7:0]               host_addr;             // Register byte address
    logic [REG_WIDTH-1:0]     host_wdata;            // Write data
    logic [REG_WIDTH-1:0]     host_rdata;            // Registered read data
    logic                     transmit_driver_on;    // Master transmit pin
    logic [CHANNEL_COUNT-1:0] tx_pos_data;           // Transmit data, positive leg
    logic [CHANNEL_COUNT-1:0] tx_neg_data;           // Transmit data, negative leg
    logic [CHANNEL_COUNT-1:0] line_out_positive;     // Line output, positive leg
    logic [CHANNEL_COUNT-1:0] line_out_positive_oe;  // Driver enable, positive leg
    logic [CHANNEL_COUNT-1:0] line_out_negative;     // Line output, negative leg
    logic [CHANNEL_COUNT-1:0] line_out_negative_oe;  // Driver enable, negative leg
    logic [RX_CHANNELS-1:0]   line_in_positive;      // Receive pins, positive leg
    logic [RX_CHANNELS-1:0]   line_in_negative;      // Receive pins, negative leg
    logic [RX_CHANNELS-1:0]   receive_input_on;      // Receiver enables
    logic [RX_CHANNELS-1:0]   rx_pos_data;           // Masked receive data, positive
    logic [RX_CHANNELS-1:0]   rx_neg_data;           // Masked receive data, negative
    int                       bad_count;             // Mismatches seen
    int                       checked;               // Comparisons made
    logic [7:0]               rd_val;                // Last value read back

    line_driver_enables dut (
        .clk_sys(clk_sys), .reset(reset), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .transmit_driver_on(transmit_driver_on), .tx_pos_data(tx_pos_data), .tx_neg_data(tx_neg_data),
        .line_out_positive(line_out_positive), .line_out_positive_oe(line_out_positive_oe),
        .line_out_negative(line_out_negative), .line_out_negative_oe(line_out_negative_oe),
        .line_in_positive(line_in_positive), .line_in_negative(line_in_negative),
        .receive_input_on(receive_input_on), .rx_pos_data(rx_pos_data), .rx_neg_data(rx_neg_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, bus tasks and comparisons
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Advance n edges, then step off the edge so drives never race sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // One write, held across exactly one taking edge; an idle edge follows so the
    // next request never raises a strobe in the same step that this one lowers it
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        host_cs    = 1'b1;
        host_wr    = 1'b1;
        host_addr  = addr;
        host_wdata = data;
        tick(1);
        host_cs = 1'b0;
        host_wr = 1'b0;
        tick(1);
    endtask : write_reg

    // One read; an extra edge is safe because read data stands until the next read
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        host_cs   = 1'b1;
        host_rd   = 1'b1;
        host_addr = addr;
        tick(1);
        host_cs = 1'b0;
        host_rd = 1'b0;
        tick(1);
        data = host_rdata;
    endtask : read_reg

    task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected 8'h%h seen 8'h%h", name, exp, got);
        end
    endtask : chk_reg

    task automatic chk_pins(input string name, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected 12'h%h seen 12'h%h", name, exp, got);
        end
    endtask : chk_pins

    task automatic stop_test;
        $display("Counts: %0d comparisons, %0d mismatches", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset;
        read_reg(TX_ENABLE_LOW_OFFSET, rd_val);
        chk_reg("tx_low reset", 8'h00, rd_val);
        read_reg(RX_ENABLE_LOW_OFFSET, rd_val);
        chk_reg("rx_low reset", 8'h00, rd_val);
        read_reg(TX_ENABLE_HIGH_OFFSET, rd_val);
        chk_reg("tx_high reset", 8'h00, rd_val);
        chk_pins("oe after reset", 12'h000, line_out_positive_oe);
        $display("test reset done");
    endtask : test_reset

    // Reserved bits dropped, enabled channels drive, cleared ones tri-state
    task automatic test_tx_low;
        write_reg(TX_ENABLE_LOW_OFFSET, 8'hFF);
        read_reg(TX_ENABLE_LOW_OFFSET, rd_val);
        chk_reg("tx_low rdback", 8'h3F, rd_val);
        tick(4);
        chk_pins("oe pos all", 12'h03F, line_out_positive_oe);
        chk_pins("line pos data", tx_pos_data, line_out_positive);
        write_reg(TX_ENABLE_LOW_OFFSET, 8'h2A);
        tick(4);
        chk_pins("oe pos 2A", 12'h02A, line_out_positive_oe);
        chk_pins("oe neg 2A", 12'h02A, line_out_negative_oe);
        $display("test tx_low done");
    endtask : test_tx_low

    // Upper register maps bit k to channel k+6
    task automatic test_tx_high;
        write_reg(TX_ENABLE_HIGH_OFFSET, 8'hC5);
        read_reg(TX_ENABLE_HIGH_OFFSET, rd_val);
        chk_reg("tx_high rdback", 8'h05, rd_val);
        tick(4);
        chk_pins("oe pos high", 12'h16A, line_out_positive_oe);
        chk_pins("line neg data", tx_neg_data, line_out_negative);
        $display("test tx_high done");
    endtask : test_tx_high

    // Master pin low must silence every channel whatever the registers hold
    task automatic test_master;
        transmit_driver_on = 1'b0;
        tick(4);
        chk_pins("oe pos master off", 12'h000, line_out_positive_oe);
        chk_pins("oe neg master off", 12'h000, line_out_negative_oe);
        transmit_driver_on = 1'b1;
        tick(4);
        chk_pins("oe pos master on", 12'h16A, line_out_positive_oe);
        $display("test master done");
    endtask : test_master

    // Receivers enabled in two patterns, 0x19 then 0x26; disabled ones pass no pulses
    task automatic test_rx;
        write_reg(RX_ENABLE_LOW_OFFSET, 8'hD9);
        read_reg(RX_ENABLE_LOW_OFFSET, rd_val);
        chk_reg("rx_low rdback", 8'h19, rd_val);
        tick(4);
        chk_pins("rx on 19", 12'h019, {6'h00, receive_input_on});
        chk_pins("rx pos 19", 12'h019, {6'h00, rx_pos_data});
        chk_pins("rx neg 19", 12'h008, {6'h00, rx_neg_data});
        write_reg(RX_ENABLE_LOW_OFFSET, 8'h26);
        tick(4);
        chk_pins("rx on 26", 12'h026, {6'h00, receive_input_on});
        chk_pins("rx neg 26", 12'h022, {6'h00, rx_neg_data});
        $display("test rx done");
    endtask : test_rx

    // Writes elsewhere leave both transmit registers untouched
    task automatic test_unmapped;
        write_reg(8'h01, 8'h3F);
        write_reg(8'h88, 8'h3F);
        read_reg(8'h88, rd_val);
        chk_reg("unmapped read", 8'h00, rd_val);
        read_reg(TX_ENABLE_LOW_OFFSET, rd_val);
        chk_reg("tx_low kept", 8'h2A, rd_val);
        chk_pins("oe kept", 12'h16A, line_out_positive_oe);
        $display("test unmapped done");
    endtask : test_unmapped

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        bad_count          = 0;
        checked            = 0;
        reset              = 1'b1;
        host_cs            = 1'b0;
        host_wr            = 1'b0;
        host_rd            = 1'b0;
        host_addr          = 8'h00;
        host_wdata         = 8'h00;
        transmit_driver_on = 1'b1;
        tx_pos_data        = 12'hA5C;
        tx_neg_data        = 12'h5A3;
        line_in_positive   = 6'h3F;
        line_in_negative   = 6'h2A;
        tick(5);
        reset = 1'b0;
        test_reset();
        test_tx_low();
        test_tx_high();
        test_master();
        test_rx();
        test_unmapped();
        stop_test();
    end

    // A hang counts as a mismatch and still reaches the verdict
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule : line_driver_redundancy_enables_tb

`default_nettype wire
